// ---- verilog/rt_pkg.sv ----
// Shared constants, types and helpers for the remote-terminal block
package rt_pkg;

   // ****************************************
   // Serial word format
   // ****************************************
   localparam int WORD_BITS = 20;
   localparam int DATA_BITS = 16;
   localparam int SYNC_BITS = 3;
   localparam logic [4:0] LAST_BIT = 5'h13;
   localparam logic [2:0] SYNC_CMD = 3'h6;
   localparam logic [2:0] SYNC_DATA = 3'h1;

   // ****************************************
   // Command word fields
   // ****************************************
   localparam int TA_LSB = 11;
   localparam int TR_BIT = 10;
   localparam int SA_LSB = 5;
   localparam int WC_LSB = 0;
   localparam int IWB_TA_LSB = 8;
   localparam logic [5:0] WC_ZERO_MEANS = 6'h20;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [15:0] WORD_RST = 16'h0000;
   localparam logic [3:0] HI_ADDR_RST = 4'h0;

   typedef enum logic [3:0] {
      ST_IDLE, ST_LOAD, ST_RX_WAIT, ST_WR_REQ, ST_WR_DO, ST_STATUS,
      ST_STATUS_WAIT, ST_RD_REQ, ST_RD_DO, ST_DATA_TX, ST_TX_WAIT, ST_DONE
   } seq_state_t;

   // Bit that makes the word plus parity hold an odd count of ones
   function automatic logic odd_par(input logic [15:0] data);
      odd_par = ~(^data);
   endfunction : odd_par

endpackage : rt_pkg

// ---- verilog/word_if.sv ----
// Word-level carrier between the sequencer and the bit processor
`timescale 1ns/1ps
interface word_if;
   logic [15:0] rx_data;
   logic rx_valid;
   logic rx_cmd;
   logic rx_perr;
   logic rx_mine;
   logic [15:0] tx_data;
   logic tx_status;
   logic tx_start;
   logic tx_busy;

   modport codec
   (
      output rx_data, rx_valid, rx_cmd, rx_perr, rx_mine, tx_busy,
      input tx_data, tx_status, tx_start
   );
   modport seq
   (
      input rx_data, rx_valid, rx_cmd, rx_perr, rx_mine, tx_busy,
      output tx_data, tx_status, tx_start
   );
endinterface : word_if

// ---- verilog/bit_processor.sv ----
// Serial to parallel and parallel to serial word conversion
`timescale 1ns/1ps
module bit_processor
   import rt_pkg::*;
(
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic [4:0] terminal_address_strap,
   input wire logic rx_bit,
   input wire logic rx_bit_en,
   input wire logic tx_bit_en,
   output logic tx_bit,
   output logic tx_bit_valid,
   word_if.codec wif
);
   logic [19:0] rsr_q;
   logic [4:0] rcnt_q;
   logic [19:0] tsr_q;
   logic [4:0] tcnt_q;
   logic [19:0] rx_full;
   logic rx_last;
   logic tx_load;
   logic tx_last;

   // ****************************************
   // Receive side
   // ****************************************
   assign rx_full = {rsr_q[18:0], rx_bit};
   assign rx_last = rx_bit_en && (rcnt_q == LAST_BIT);

   // (RULE_01) (RULE_02) twenty-bit word, parity check
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         rsr_q <= '0;
         rcnt_q <= '0;
         wif.rx_valid <= 1'b0;
         wif.rx_data <= WORD_RST;
         wif.rx_cmd <= 1'b0;
         wif.rx_perr <= 1'b0;
         wif.rx_mine <= 1'b0;
      end
      else if (ce)
      begin
         wif.rx_valid <= rx_last;
         if (rx_bit_en)
         begin
            rsr_q <= rx_full;
            rcnt_q <= rx_last ? 5'h00 : rcnt_q + 5'h01;
         end
         if (rx_last)
         begin
            wif.rx_data <= rx_full[16:1];
            wif.rx_cmd <= (rx_full[19:17] == SYNC_CMD);
            wif.rx_perr <= (rx_full[0] != odd_par(rx_full[16:1]));
            // (RULE_13) match against strapped address
            wif.rx_mine <= (rx_full[16:12] == terminal_address_strap);
         end
      end
   end

   // ****************************************
   // Transmit side
   // ****************************************
   assign tx_load = wif.tx_start && !wif.tx_busy;
   assign tx_last = tx_bit_en && wif.tx_busy && (tcnt_q == LAST_BIT);

   // (RULE_02) parallel to serial, MSB first
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         tsr_q <= '0;
         tcnt_q <= '0;
         wif.tx_busy <= 1'b0;
         tx_bit <= 1'b0;
         tx_bit_valid <= 1'b0;
      end
      else if (ce)
      begin
         tx_bit_valid <= tx_bit_en && wif.tx_busy;
         if (tx_load)
         begin
            tsr_q <= {wif.tx_status ? SYNC_CMD : SYNC_DATA, wif.tx_data,
                      odd_par(wif.tx_data)};
            tcnt_q <= '0;
            wif.tx_busy <= 1'b1;
         end
         else if (tx_bit_en && wif.tx_busy)
         begin
            tx_bit <= tsr_q[19];
            tsr_q <= {tsr_q[18:0], 1'b0};
            tcnt_q <= tcnt_q + 5'h01;
            if (tx_last)
               wif.tx_busy <= 1'b0;
         end
      end
   end

   a_tx_start_busy : assert property (  // RULE_01
      @(posedge sys_clk) disable iff (!nrst || !ce)
      tx_load |=> wif.tx_busy)
      else $error("transmit start did not set busy");

endmodule : bit_processor

// ---- verilog/rt_terminal.sv ----
// Remote-terminal sequencer with host bus address and strobe generation
//
// What this block does
// (RULE_01) Serial words: sixteen data, three sync, parity.
// (RULE_02) Check parity, convert serial and parallel words.
// (RULE_03) Drive twenty-bit host address when enabled.
// (RULE_04) Request host bus, wait for acknowledge.
// (RULE_05) Init pulse restarts sequencer at start state.
// (RULE_06) State decodes strobes, interrupt and bus request.
// (RULE_07) State feeds sequencer forming next state.
// (RULE_08) Strapped address registered onto word bus bits.
// (RULE_09) Word bus low bits drive upper address.
// (RULE_10) Start address preloads sixteen-bit up counter.
// (RULE_11) Latch command low byte and command flag.
// (RULE_12) One status word after validated receive.
// (RULE_13) Answer only own terminal address.
// (RULE_14) Transmit: status then commanded data words.
// (RULE_15) Outgoing data read from SRAM, then sent.
// (RULE_16) Host controller decodes address to interface enable.
// (RULE_17) No bus drive before acknowledge; release after.
// (RULE_18) Parity error voids message, no status.
// (RULE_19) Pulse host interrupt when message completes.
`timescale 1ns/1ps
module rt_terminal
   import rt_pkg::*;
(
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic init_pulse,
   input wire logic [4:0] terminal_address_strap,
   input wire logic iface_enable,
   input wire logic bus_ack,
   input wire logic [15:0] host_data_in,
   input wire logic rx_bit,
   input wire logic rx_bit_en,
   input wire logic tx_bit_en,
   output logic bus_req,
   output logic [19:0] host_addr,
   output logic host_addr_oe_n,
   output logic [15:0] host_data_out,
   output logic host_data_oe_n,
   output logic upper_byte_enable,
   output logic io_read_strobe,
   output logic io_write_strobe,
   output logic host_irq,
   output logic tx_bit,
   output logic tx_bit_valid
);
   import rt_pkg::*;

   seq_state_t st_q, st_d;
   logic [4:0] ta_q;
   logic [7:0] cmd_low_q;
   logic latched_command_flag;
   logic [4:0] subaddr_q;
   logic [3:0] addr_hi_q;
   logic [15:0] addr_cnt_q;
   logic [15:0] transfer_start_address;
   logic [5:0] remain_q;
   logic [15:0] data_q;
   logic [15:0] internal_word_bus;
   logic [5:0] word_count;
   logic cmd_ok;
   logic bus_grant;
   logic own_d;
   logic last_word;

   word_if wif ();

   bit_processor u_bitproc
   (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .ce(ce),
      .terminal_address_strap(terminal_address_strap),
      .rx_bit(rx_bit),
      .rx_bit_en(rx_bit_en),
      .tx_bit_en(tx_bit_en),
      .tx_bit(tx_bit),
      .tx_bit_valid(tx_bit_valid),
      .wif(wif.codec)
   );

   // ****************************************
   // Decode
   // ****************************************
   // (RULE_08) terminal address on word bus bits 8 to 12
   assign internal_word_bus = {3'h0, ta_q, 3'h0, subaddr_q};
   assign transfer_start_address = internal_word_bus;
   assign word_count = (wif.rx_data[4:0] == 5'h00) ? WC_ZERO_MEANS
                       : {1'b0, wif.rx_data[4:0]};
   // (RULE_13) (RULE_18) only clean command words for this terminal
   assign cmd_ok = wif.rx_valid && wif.rx_cmd && !wif.rx_perr
                   && wif.rx_mine;
   // (RULE_04) (RULE_03) acknowledge plus interface enable grants bus
   assign bus_grant = bus_ack && iface_enable;
   assign last_word = (remain_q == 6'h01);
   assign wif.tx_status = (st_q == ST_STATUS);
   assign wif.tx_start = (st_q == ST_STATUS) || (st_q == ST_DATA_TX);
   assign wif.tx_data = (st_q == ST_STATUS)
                        ? {ta_q, 11'h000} : data_q;
   // (RULE_17) drive only in states entered under acknowledge
   assign own_d = (st_d == ST_WR_DO) || (st_d == ST_RD_DO);

   // ****************************************
   // Next state
   // ****************************************
   // (RULE_07) (RULE_11) current state and command flag pick next
   always_comb
   begin
      st_d = st_q;
      case (st_q)
         ST_IDLE:
            if (cmd_ok)
               st_d = ST_LOAD;
         ST_LOAD:
            st_d = latched_command_flag ? ST_STATUS : ST_RX_WAIT;
         ST_RX_WAIT:
            if (wif.rx_valid)
               // (RULE_18) bad or stray word voids the message
               st_d = (wif.rx_perr || wif.rx_cmd) ? ST_IDLE : ST_WR_REQ;
         ST_WR_REQ:
            if (bus_grant)
               st_d = ST_WR_DO;
         ST_WR_DO:
            // (RULE_12) status only after all data words
            st_d = last_word ? ST_STATUS : ST_RX_WAIT;
         ST_STATUS:
            st_d = ST_STATUS_WAIT;
         ST_STATUS_WAIT:
            if (!wif.tx_busy)
               // (RULE_14) transmit continues with data words
               st_d = latched_command_flag ? ST_RD_REQ : ST_DONE;
         ST_RD_REQ:
            if (bus_grant)
               st_d = ST_RD_DO;
         ST_RD_DO:
            st_d = ST_DATA_TX;
         ST_DATA_TX:
            st_d = ST_TX_WAIT;
         ST_TX_WAIT:
            if (!wif.tx_busy)
               st_d = (remain_q == 6'h00) ? ST_DONE : ST_RD_REQ;
         ST_DONE:
            st_d = ST_IDLE;
         default:
            st_d = ST_IDLE;
      endcase
   end

   // ****************************************
   // Sequencer state and command latch
   // ****************************************
   // (RULE_05) init pulse returns to start state
   always_ff @(posedge sys_clk)
   begin
      if (!nrst || (ce && init_pulse))
         st_q <= ST_IDLE;
      else if (ce)
         st_q <= st_d;
   end

   // Strap sampled by clock so reset takes only constants
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         ta_q <= '0;
         cmd_low_q <= '0;
         latched_command_flag <= 1'b0;
         subaddr_q <= '0;
      end
      else if (ce)
      begin
         // (RULE_08) terminal address register
         ta_q <= terminal_address_strap;
         if (st_q == ST_IDLE && cmd_ok)
         begin
            // (RULE_11) latch low byte and direction flag
            cmd_low_q <= wif.rx_data[7:0];
            latched_command_flag <= wif.rx_data[TR_BIT];
            subaddr_q <= wif.rx_data[TA_LSB-2:SA_LSB];
         end
      end
   end

   // ****************************************
   // Address generation and data path
   // ****************************************
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         addr_hi_q <= HI_ADDR_RST;
         addr_cnt_q <= WORD_RST;
         remain_q <= '0;
         data_q <= WORD_RST;
      end
      else if (ce)
      begin
         if (st_q == ST_IDLE && cmd_ok)
            remain_q <= word_count;
         if (st_q == ST_LOAD)
         begin
            // (RULE_09) (RULE_10) upper bits and counter preload
            addr_hi_q <= internal_word_bus[3:0];
            addr_cnt_q <= transfer_start_address;
         end
         if (st_q == ST_RX_WAIT && wif.rx_valid)
            data_q <= wif.rx_data;
         if (st_q == ST_RD_DO)
            // (RULE_15) SRAM word latched for serial conversion
            data_q <= host_data_in;
         if (st_q == ST_WR_DO || st_q == ST_RD_DO)
         begin
            // (RULE_10) counter steps once per word
            addr_cnt_q <= addr_cnt_q + 16'h0001;
            remain_q <= remain_q - 6'h01;
         end
      end
   end

   // ****************************************
   // Registered host bus outputs
   // ****************************************
   // (RULE_06) (RULE_17) request, enables, strobes and interrupt decoded from next state; address from current state
   always_ff @(posedge sys_clk)
   begin
      if (!nrst || (ce && init_pulse))
      begin
         bus_req <= 1'b0;
         host_addr <= '0;
         host_addr_oe_n <= 1'b1;
         host_data_out <= WORD_RST;
         host_data_oe_n <= 1'b1;
         upper_byte_enable <= 1'b0;
         io_read_strobe <= 1'b0;
         io_write_strobe <= 1'b0;
         host_irq <= 1'b0;
      end
      else if (ce)
      begin
         // (RULE_04) request held until the word is moved
         bus_req <= (st_d == ST_WR_REQ) || (st_d == ST_RD_REQ) || own_d;
         // (RULE_03) twenty-bit address
         host_addr <= (st_q == ST_LOAD)
                      ? {internal_word_bus[3:0], transfer_start_address}
                      : {addr_hi_q, (st_q == ST_WR_DO || st_q == ST_RD_DO)
                         ? addr_cnt_q + 16'h0001 : addr_cnt_q};
         host_addr_oe_n <= !own_d;
         host_data_out <= data_q;
         host_data_oe_n <= !(st_d == ST_WR_DO);
         upper_byte_enable <= own_d;
         io_read_strobe <= (st_d == ST_RD_DO);
         io_write_strobe <= (st_d == ST_WR_DO);
         // (RULE_19) one-cycle completion interrupt
         host_irq <= (st_d == ST_DONE);
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   a_write_after_ack : assert property (  // RULE_17
      @(posedge sys_clk) disable iff (!nrst || !ce)
      $rose(io_write_strobe) |-> $past(bus_ack) && bus_req)
      else $error("write strobe without acknowledge");

   a_read_drives_bus : assert property (  // RULE_04
      @(posedge sys_clk) disable iff (!nrst || !ce)
      io_read_strobe |-> bus_req && !host_addr_oe_n)
      else $error("read strobe without bus ownership");

   a_irq_one_cycle : assert property (  // RULE_19
      @(posedge sys_clk) disable iff (!nrst || !ce)
      host_irq |=> !host_irq ##1 !host_irq)
      else $error("interrupt longer than one cycle");

   a_init_restart : assert property (  // RULE_05
      @(posedge sys_clk) disable iff (!nrst)
      ce && init_pulse |=> st_q == ST_IDLE && !bus_req)
      else $error("init did not restart sequencer");

   a_release_done : assert property (  // RULE_17
      @(posedge sys_clk) disable iff (!nrst || !ce)
      st_q == ST_DONE |-> host_addr_oe_n && !bus_req && host_data_oe_n)
      else $error("bus held after transfer end");

   a_addr_steps : assert property (  // RULE_10
      @(posedge sys_clk) disable iff (!nrst || !ce)
      $fell(io_write_strobe) |->
         addr_cnt_q == $past(host_addr[15:0], 1) + 16'h0001)
      else $error("address counter did not step");

   a_perr_no_status : assert property (  // RULE_18
      @(posedge sys_clk) disable iff (!nrst || !ce)
      st_q == ST_RX_WAIT && wif.rx_valid && wif.rx_perr |=>
         st_q == ST_IDLE ##1 st_q != ST_STATUS)
      else $error("status sent for bad message");

   a_foreign_ignored : assert property (  // RULE_13
      @(posedge sys_clk) disable iff (!nrst || !ce || init_pulse)
      st_q == ST_IDLE && wif.rx_valid && !wif.rx_mine |=> st_q == ST_IDLE)
      else $error("answered another terminal address");

   a_hi_addr_out : assert property (  // RULE_09
      @(posedge sys_clk) disable iff (!nrst || !ce)
      !host_addr_oe_n |-> host_addr[19:16] == internal_word_bus[3:0])
      else $error("upper address differs from word bus");

endmodule : rt_terminal

// ---- dv/bc_model.sv ----
// Bus controller model: sends serial words, collects the replies
`timescale 1ns/1ps
module bc_model
(
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic tx_bit,
   input wire logic tx_bit_valid,
   output logic rx_bit,
   output logic rx_bit_en
);
   logic [19:0] sh_q;
   int cnt;
   logic [19:0] got[$];

   initial
   begin
      rx_bit = 1'b0;
      rx_bit_en = 1'b0;
      sh_q = 20'h00000;
      cnt = 0;
   end

   // ****************************************
   // Sending
   // ****************************************
   // twenty bit words
   task automatic send(input logic [2:0] sy, input logic [15:0] d,
                       input logic bad);
      logic [19:0] w;
      w = {sy, d, ~(^d) ^ bad};
      for (int i = 19; i >= 0; i--)
      begin
         @(posedge sys_clk);
         rx_bit_en <= 1'b1;
         rx_bit <= w[i];
      end
      @(posedge sys_clk);
      rx_bit_en <= 1'b0;
      // Line released: inverse of last bit, never a stale copy
      rx_bit <= ~w[0];
   endtask : send

   // ****************************************
   // Collecting
   // ****************************************
   // frame of twenty
   always @(posedge sys_clk)
   begin
      if (!nrst)
         cnt = 0;
      else if (tx_bit_valid)
      begin
         sh_q = {sh_q[18:0], tx_bit};
         cnt++;
         if (cnt == 20)
         begin
            got.push_back(sh_q);
            cnt = 0;
         end
      end
   end
endmodule : bc_model

// ---- dv/test_mil1553_remote_terminal_dma.sv ----
// Self-checking bench for the remote-terminal block
`timescale 1ns/1ps
module test_mil1553_remote_terminal_dma;
   import rt_pkg::*;
   logic sys_clk, nrst, ce, init_pulse, iface_enable, bus_ack, tx_bit_en;
   logic [4:0] ta;
   logic [15:0] host_data_in, host_data_out;
   logic [19:0] host_addr;
   logic rx_bit, rx_bit_en, bus_req, host_addr_oe_n, host_data_oe_n;
   logic upper_byte_enable, io_read_strobe, io_write_strobe;
   logic host_irq, tx_bit, tx_bit_valid;
   int mismatches, n_checks, cyc, irq_n, gnt;
   logic [35:0] wr_q[$];
   logic [19:0] rd_q[$];

   rt_terminal i_dut (.sys_clk(sys_clk), .nrst(nrst), .ce(ce),
      .init_pulse(init_pulse), .terminal_address_strap(ta),
      .iface_enable(iface_enable), .bus_ack(bus_ack),
      .host_data_in(host_data_in), .rx_bit(rx_bit), .rx_bit_en(rx_bit_en),
      .tx_bit_en(tx_bit_en), .bus_req(bus_req), .host_addr(host_addr),
      .host_addr_oe_n(host_addr_oe_n), .host_data_out(host_data_out),
      .host_data_oe_n(host_data_oe_n),
      .upper_byte_enable(upper_byte_enable),
      .io_read_strobe(io_read_strobe), .io_write_strobe(io_write_strobe),
      .host_irq(host_irq), .tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid));

   bc_model i_bc (.sys_clk(sys_clk), .nrst(nrst), .tx_bit(tx_bit),
      .tx_bit_valid(tx_bit_valid), .rx_bit(rx_bit), .rx_bit_en(rx_bit_en));

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [15:0] pat(input logic [19:0] a);
      pat = a[15:0] ^ 16'h3c5a ^ {a[19:16], 12'h000};
   endfunction : pat

   function automatic logic [15:0] dat(input int i);
      dat = 16'h9e37 ^ {i[7:0], i[7:0]};
   endfunction : dat

   function automatic logic [19:0] wrd(input logic [2:0] s,
                                       input logic [15:0] d);
      wrd = {s, d, ~(^d)};
   endfunction : wrd

   function automatic logic [19:0] adr(input logic [4:0] sa, input int i);
      adr = {sa[3:0], 3'h0, ta, 3'h0, sa};
      adr[15:0] = adr[15:0] + i[15:0];
   endfunction : adr

   task automatic chk(input string nm, input logic [35:0] e,
                      input logic [35:0] g);
      n_checks++;
      if (g !== e)
      begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic end_sim;
      if (mismatches == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : end_sim

   task automatic clr;
      i_bc.got.delete();
      wr_q.delete();
      rd_q.delete();
      irq_n = 0;
   endtask : clr

   task automatic wait_words(input int n);
      int k;
      k = 0;
      while (i_bc.got.size() < n && k < 3000)
      begin
         @(posedge sys_clk);
         k++;
      end
      repeat (100) @(posedge sys_clk);
   endtask : wait_words

   // ****************************************
   // Host bus controller, SRAM and monitors
   // ****************************************
   // Memory answers only under the read strobe
   assign host_data_in = io_read_strobe ? pat(host_addr) : ~pat(host_addr);

   // Ceiling well above the longest scenario chain
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc > 60000)
      begin
         mismatches++;
         end_sim();
      end
   end

   always @(posedge sys_clk)
   begin
      tx_bit_en <= ~tx_bit_en;
      // slow grant, enable decoded with it
      if (!bus_req)
      begin
         gnt <= 0;
         bus_ack <= 1'b0;
         iface_enable <= 1'b0;
      end
      else if (gnt == 3)
      begin
         bus_ack <= 1'b1;
         iface_enable <= 1'b1;
      end
      else
         gnt <= gnt + 1;
      if (io_write_strobe)
         wr_q.push_back({host_addr, host_data_out});
      if (io_read_strobe)
         rd_q.push_back(host_addr);
      if (host_irq)
         irq_n++;
      if (io_read_strobe | io_write_strobe)
         chk("grant held", 2'b11, {bus_ack, upper_byte_enable});
      if (io_write_strobe)
         chk("write oe", 2'b00, {host_addr_oe_n, host_data_oe_n});
      if (nrst && !bus_req && !bus_ack)
         chk("released", 4'hc, {host_addr_oe_n, host_data_oe_n,
            io_read_strobe, io_write_strobe});
   end

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_rx(input logic [4:0] sa, input logic [4:0] wc);
      int n;
      n = (wc == 5'd0) ? 32 : int'(wc);
      clr();
      i_bc.send(3'b110, {ta, 1'b0, sa, wc}, 1'b0);
      for (int i = 0; i < n; i++)
         i_bc.send(3'b001, dat(i), 1'b0);
      wait_words(1);
      chk("rx replies", 1, i_bc.got.size());
      chk("status", wrd(3'b110, {ta, 11'h000}), i_bc.got[0]);
      chk("write count", n, wr_q.size());
      for (int i = 0; i < n; i++)
         chk("sram write", {adr(sa, i), dat(i)}, wr_q[i]);
      chk("irq pulses", 1, irq_n);
   endtask : t_rx

   task automatic t_tx(input logic [4:0] sa, input logic [4:0] wc);
      clr();
      i_bc.send(3'b110, {ta, 1'b1, sa, wc}, 1'b0);
      wait_words(int'(wc) + 1);
      chk("tx replies", wc + 1, i_bc.got.size());
      chk("tx status", wrd(3'b110, {ta, 11'h000}), i_bc.got[0]);
      for (int k = 0; k < int'(wc); k++)
      begin
         chk("read addr", adr(sa, k), rd_q[k]);
         chk("tx data", wrd(3'b001, pat(adr(sa, k))),
            i_bc.got[k + 1]);
      end
      chk("irq pulses", 1, irq_n);
   endtask : t_tx

   // Stray data word, then a command for another terminal
   task automatic t_foreign;
      clr();
      i_bc.send(3'b001, 16'h1234, 1'b0);
      i_bc.send(3'b110, {ta ^ 5'h01, 1'b0, 5'h02, 5'd1}, 1'b0);
      i_bc.send(3'b001, 16'h4321, 1'b0);
      repeat (200) @(posedge sys_clk);
      chk("foreign quiet", 0, i_bc.got.size() + wr_q.size());
      chk("foreign irq", 0, irq_n);
   endtask : t_foreign

   task automatic t_parity;
      clr();
      i_bc.send(3'b110, {ta, 1'b0, 5'h04, 5'd2}, 1'b0);
      i_bc.send(3'b001, dat(0), 1'b0);
      i_bc.send(3'b001, dat(1), 1'b1);
      repeat (200) @(posedge sys_clk);
      chk("bad parity reply", 0, i_bc.got.size());
      chk("partial write", 1, wr_q.size());
      chk("bad parity irq", 0, irq_n);
   endtask : t_parity

   task automatic t_init;
      int k;
      clr();
      k = 0;
      i_bc.send(3'b110, {ta, 1'b1, 5'h07, 5'd4}, 1'b0);
      while (bus_req !== 1'b1 && k < 2000)
      begin
         @(posedge sys_clk);
         k++;
      end
      // Freeze while the grant arrives: no read may start
      ce <= 1'b0;
      repeat (10) @(posedge sys_clk);
      chk("ce freeze", 2'b10, {bus_req, io_read_strobe});
      init_pulse <= 1'b1;
      ce <= 1'b1;
      @(posedge sys_clk);
      init_pulse <= 1'b0;
      repeat (2) @(posedge sys_clk);
      chk("init drop", 2'b01, {bus_req, host_addr_oe_n});
      repeat (300) @(posedge sys_clk);
      chk("reads stop", 0, rd_q.size());
      chk("init irq", 0, irq_n);
   endtask : t_init

   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   initial
   begin
      nrst = 1'b0;
      ce = 1'b1;
      init_pulse = 1'b0;
      iface_enable = 1'b0;
      bus_ack = 1'b0;
      tx_bit_en = 1'b0;
      ta = 5'h15;
      mismatches = 0;
      n_checks = 0;
      cyc = 0;
      irq_n = 0;
      gnt = 0;
      repeat (8) @(posedge sys_clk);
      nrst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      t_rx(5'h03, 5'd2);
      t_tx(5'h1e, 5'd3);
      t_foreign();
      t_parity();
      t_init();
      ta <= 5'h0a;
      // New strap must settle before the command word is built
      @(posedge sys_clk);
      t_tx(5'h19, 5'd2);
      t_rx(5'h11, 5'd0);
      end_sim();
   end
endmodule : test_mil1553_remote_terminal_dma
